/* File: core/gpio_led_map.vh */
`ifndef GPIO_LED_MAP_VH
`define GPIO_LED_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_DEVICE_CONFIG 8'h01
`define OFS_LED_SINK_ENABLE 8'h31
`define OFS_GLOBAL_CONFIG 8'h40
`define PTR_AUTO_LO 8'h31
`define PTR_AUTO_HI 8'h5b

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CFG_TIMEOUT_DIS_BIT 0
`define GLB_SOFT_RESET_BIT 4
`define RST_DEVICE_CONFIG 8'h0b
`define CFG_WRITE_MASK 8'h01
`define RST_LED_SINK_ENABLE 8'h00
`define LED_WRITE_MASK 8'h0f
`define RST_GLOBAL_CONFIG 8'h00
`define RST_POINTER 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define BUS_TIMEOUT_MS 20
// Twenty milliseconds of the 40 MHz clock, sized to the 24-bit gap counter.
`define BUS_TIMEOUT_CYC 24'd800000
`define PWM_STEP_DIV 40
`define PWM_PHASE_STEP 8'h20

`endif

/* File: core/bus_watch.v */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_led_map.vh"

module bus_watch #(
  parameter [23:0] TIMEOUT_CYC = `BUS_TIMEOUT_CYC
) (
  input wire clk,
  input wire nrst,
  input wire scl_pin,
  input wire sda_pin,
  input wire timeout_dis,
  output reg start_det_ff,
  output reg stop_det_ff,
  output reg timeout_ff,
  output reg locked_ff
);

  reg scl_s1_ff, scl_s2_ff, scl_d_ff;
  reg sda_s1_ff, sda_s2_ff, sda_d_ff;
  reg busy_ff;
  reg [23:0] gap_ff;
  wire scl_edge;
  wire start_c;
  wire stop_c;

  assign scl_edge = scl_s2_ff ^ scl_d_ff;
  assign start_c = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign stop_c = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

  always @(posedge clk) begin
    if (!nrst) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      busy_ff <= 1'b0;
      gap_ff <= 24'h000000;
      start_det_ff <= 1'b0;
      stop_det_ff <= 1'b0;
      timeout_ff <= 1'b0;
      locked_ff <= 1'b0;
    end else begin
      scl_s1_ff <= scl_pin;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_pin;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
      start_det_ff <= start_c;
      stop_det_ff <= stop_c;
      timeout_ff <= 1'b0;
      if (start_c) begin
        busy_ff <= 1'b1;
        gap_ff <= 24'h000000;
        // R8: START releases
        locked_ff <= 1'b0;
      end else if (stop_c) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        if (scl_edge) begin
          gap_ff <= 24'h000000;
        end else if (gap_ff >= TIMEOUT_CYC) begin
          // R7: gap too long
          if (!timeout_dis) begin
            timeout_ff <= 1'b1;
            locked_ff <= 1'b1;
            busy_ff <= 1'b0;
          end
          gap_ff <= 24'h000000;
        end else begin
          gap_ff <= gap_ff + 24'h000001;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: core/gpio_led_regs.v */
// Overview of operation
// R1: Stored pointer steps by one after each data byte within 0x31 to 0x5B.
// R2: Stepping happens only between data bytes of a transaction, never otherwise.
// R3: Writing one to global configuration D4 restores every register to reset.
// R4: LED port PWM starts are staggered by 45 degrees over four positions.
// R5: Configuration D0 disables bus timeout; D[7:1] reserved, reset 0000101.
// R6: LED enable D3..D0 select LED sink for ports fifteen down to twelve.
// R7: With timeout enabled, an SCL edge gap over 20 ms aborts the transaction.
// R8: After timeout, byte traffic is ignored until a new START arrives.
// R9: First written byte becomes the pointer; a STOP then ends with nothing else.
// R10: Reads fetch from the pointer and step it like writes.
// R11: Reserved bits ignore writes and read back their reset values.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_led_map.vh"

module gpio_led_regs #(
  parameter [23:0] TIMEOUT_CYC = `BUS_TIMEOUT_CYC
) (
  input wire clk,
  input wire nrst,
  input wire scl_pin,
  input wire sda_pin,
  input wire txn_begin,
  input wire txn_read,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire tx_req,
  output reg [7:0] tx_data_ff,
  output wire txn_abort,
  output wire bus_ignore,
  output wire timeout_disable,
  output wire [3:0] constant_current_ports_led_en,
  output reg [3:0] led_phase_start_ff,
  output reg [7:0] pointer_ff
);

  // ----------------------------------------------------------------
  // Transaction states
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CMD = 2'b01;
  localparam [1:0] ST_WDATA = 2'b10;
  localparam [1:0] ST_RDATA = 2'b11;

  reg [1:0] state_ff, nxt_state;
  reg [7:0] nxt_pointer;
  reg [7:0] cfg_ff, nxt_cfg;
  reg [7:0] led_ff, nxt_led;
  reg [7:0] glb_ff, nxt_glb;
  reg [7:0] nxt_tx_data;
  reg soft_rst_ff, nxt_soft_rst;
  reg [5:0] div_ff;
  reg [7:0] pwm_ff;
  wire start_det, stop_det, timeout_pulse, locked;
  wire rx_ok, tx_ok;

  // ----------------------------------------------------------------
  // Bus watch
  // ----------------------------------------------------------------
  bus_watch #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_watch (
    .clk(clk),
    .nrst(nrst),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .timeout_dis(cfg_ff[`CFG_TIMEOUT_DIS_BIT]),
    .start_det_ff(start_det),
    .stop_det_ff(stop_det),
    .timeout_ff(timeout_pulse),
    .locked_ff(locked)
  );

  assign txn_abort = timeout_pulse;
  assign bus_ignore = locked;
  // R8: gate traffic
  assign rx_ok = rx_valid & ~locked & ~timeout_pulse;
  assign tx_ok = tx_req & ~locked & ~timeout_pulse;
  assign timeout_disable = cfg_ff[`CFG_TIMEOUT_DIS_BIT];
  assign constant_current_ports_led_en = led_ff[3:0];

  function [7:0] step_ptr;
    input [7:0] p;
    begin
      if (p >= `PTR_AUTO_LO && p < `PTR_AUTO_HI) begin
        step_ptr = p + 8'h01;
      end else if (p == `PTR_AUTO_HI) begin
        step_ptr = `PTR_AUTO_LO;
      end else begin
        step_ptr = p;
      end
    end
  endfunction

  function [7:0] read_reg;
    input [7:0] a;
    input [7:0] cfg;
    input [7:0] led;
    input [7:0] glb;
    begin
      case (a)
        `OFS_DEVICE_CONFIG: read_reg = cfg;
        `OFS_LED_SINK_ENABLE: read_reg = led;
        `OFS_GLOBAL_CONFIG: read_reg = glb;
        default: read_reg = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Transaction and register logic
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_pointer = pointer_ff;
    nxt_cfg = cfg_ff;
    nxt_led = led_ff;
    nxt_glb = glb_ff;
    nxt_tx_data = tx_data_ff;
    nxt_soft_rst = 1'b0;
    if (timeout_pulse) begin
      // R7: internal abort
      nxt_state = ST_IDLE;
    end else if (txn_begin && !locked) begin
      nxt_state = txn_read ? ST_RDATA : ST_CMD;
    end else if (stop_det || start_det) begin
      // R9: STOP after command ends here
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_CMD: begin
          if (rx_ok) begin
            // R9: command byte stored
            nxt_pointer = rx_data;
            nxt_state = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (rx_ok) begin
            case (pointer_ff)
              `OFS_DEVICE_CONFIG: begin
                // R5: D0 writable, R11: reserved held
                nxt_cfg = (`RST_DEVICE_CONFIG & ~`CFG_WRITE_MASK) |
                          (rx_data & `CFG_WRITE_MASK);
              end
              `OFS_LED_SINK_ENABLE: begin
                // R6: low nibble, R11: upper zero
                nxt_led = rx_data & `LED_WRITE_MASK;
              end
              `OFS_GLOBAL_CONFIG: begin
                nxt_glb = rx_data;
                nxt_glb[`GLB_SOFT_RESET_BIT] = 1'b0;
                // R3: software reset trigger
                nxt_soft_rst = rx_data[`GLB_SOFT_RESET_BIT];
              end
              default: begin
                nxt_glb = glb_ff;
              end
            endcase
            // R1: step after write, R2: burst only
            nxt_pointer = step_ptr(pointer_ff);
          end
        end
        ST_RDATA: begin
          if (tx_ok) begin
            // R10: fetch at pointer
            nxt_tx_data = read_reg(pointer_ff, cfg_ff, led_ff, glb_ff);
            nxt_pointer = step_ptr(pointer_ff);
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (!nrst || soft_rst_ff) begin
      // R3: restore defaults
      state_ff <= ST_IDLE;
      pointer_ff <= `RST_POINTER;
      cfg_ff <= `RST_DEVICE_CONFIG;
      led_ff <= `RST_LED_SINK_ENABLE;
      glb_ff <= `RST_GLOBAL_CONFIG;
      tx_data_ff <= 8'h00;
      soft_rst_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pointer_ff <= nxt_pointer;
      cfg_ff <= nxt_cfg;
      led_ff <= nxt_led;
      glb_ff <= nxt_glb;
      tx_data_ff <= nxt_tx_data;
      soft_rst_ff <= nxt_soft_rst;
    end
  end

  // ----------------------------------------------------------------
  // Staggered PWM start phasing
  // ----------------------------------------------------------------
  // The step counter runs on regardless of software reset so the LED
  // engine keeps a steady cycle; only the enables are cleared.
  always @(posedge clk) begin
    if (!nrst) begin
      div_ff <= 6'h00;
      pwm_ff <= 8'h00;
      led_phase_start_ff <= 4'h0;
    end else begin
      led_phase_start_ff <= 4'h0;
      if (div_ff == (`PWM_STEP_DIV - 1)) begin
        div_ff <= 6'h00;
        pwm_ff <= pwm_ff + 8'h01;
        // R4: 45 degree phase steps
        led_phase_start_ff[0] <= led_ff[0] & (pwm_ff == 8'h00);
        led_phase_start_ff[1] <= led_ff[1] & (pwm_ff == `PWM_PHASE_STEP);
        led_phase_start_ff[2] <= led_ff[2] & (pwm_ff == (`PWM_PHASE_STEP * 2));
        led_phase_start_ff[3] <= led_ff[3] & (pwm_ff == (`PWM_PHASE_STEP * 3));
      end else begin
        div_ff <= div_ff + 6'h01;
      end
    end
  end

endmodule

`default_nettype wire

/* File: core/README_unused.v */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: testbench/gpio_led_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_led_chk #(
  parameter [23:0] TIMEOUT_CYC = 24'd50
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic txn_begin,
  input wire logic txn_read,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_req,
  input wire logic txn_abort,
  input wire logic bus_ignore,
  input wire logic timeout_disable,
  input wire logic [3:0] constant_current_ports_led_en,
  input wire logic [3:0] led_phase_start_ff,
  input wire logic [7:0] pointer_ff
);
  logic rd_ff, dat_ff, seen_ff;
  logic [13:0] cnt_ff;
  wire step_q = !bus_ignore && (rd_ff ? tx_req : dat_ff && rx_valid);
  wire wr_q = dat_ff && rx_valid && !bus_ignore;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // The first written byte is the pointer, later ones are data.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_ff <= 1'b0;
      dat_ff <= 1'b0;
    end else if (txn_begin) begin
      rd_ff <= txn_read;
      dat_ff <= 1'b0;
    end else if (rx_valid) begin
      dat_ff <= 1'b1;
    end
  end
  // Cycles since the first port's start pulse, saturating.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      seen_ff <= 1'b0;
      cnt_ff <= 14'h0000;
    end else if (led_phase_start_ff[0]) begin
      seen_ff <= 1'b1;
      cnt_ff <= 14'h0001;
    end else if (cnt_ff != 14'h3fff) begin
      cnt_ff <= cnt_ff + 14'h0001;
    end
  end
  AST_PTR_STEP: assert property (
    step_q && pointer_ff >= 8'h31 && pointer_ff < 8'h5b |=> pointer_ff == $past(pointer_ff) + 8'h01)
    else $error("pointer did not step by one");
  AST_PTR_WRAP: assert property (
    step_q && pointer_ff == 8'h5b |=> pointer_ff == 8'h31)
    else $error("pointer did not wrap");
  AST_CMD_LOAD: assert property (
    !dat_ff && !rd_ff && rx_valid && !bus_ignore |=> pointer_ff == $past(rx_data))
    else $error("command byte not stored");
  AST_CFG_WR: assert property (
    wr_q && pointer_ff == 8'h01 |=> timeout_disable == $past(rx_data[0]))
    else $error("timeout disable not written");
  AST_LED_WR: assert property (
    wr_q && pointer_ff == 8'h31 |=> constant_current_ports_led_en == $past(rx_data[3:0]))
    else $error("led enable not written");
  AST_ABORT: assert property (
    txn_abort |-> !timeout_disable ##1 bus_ignore)
    else $error("abort without timeout enabled");
  AST_IGNORE: assert property (
    bus_ignore && (rx_valid || tx_req) |=> $stable(pointer_ff))
    else $error("traffic taken while ignoring");
  AST_SRST: assert property (
    wr_q && pointer_ff == 8'h40 && rx_data[4]
    |-> ##3 pointer_ff == 8'h00 && constant_current_ports_led_en == 4'h0 && timeout_disable)
    else $error("soft reset did not restore");
  AST_PHASE: assert property (
    led_phase_start_ff[1] && seen_ff && constant_current_ports_led_en[0] |-> cnt_ff == 14'd1280)
    else $error("phase spacing wrong");
  COV_ABORT: cover property (txn_abort);
  COV_PHASE: cover property (led_phase_start_ff[3]);
  COV_WRAP: cover property (step_q && pointer_ff == 8'h5b);
endmodule
bind gpio_led_regs gpio_led_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_i (.clk(clk), .nrst(nrst),
  .txn_begin(txn_begin), .txn_read(txn_read), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_req(tx_req), .txn_abort(txn_abort), .bus_ignore(bus_ignore),
  .timeout_disable(timeout_disable), .pointer_ff(pointer_ff),
  .constant_current_ports_led_en(constant_current_ports_led_en),
  .led_phase_start_ff(led_phase_start_ff));
`default_nettype wire

/* File: testbench/i2c_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  output logic scl,
  output logic sda
);
  // Both lines are pulled up; SCL stays high unless toggle_scl runs.
  // The conditions wait out the design's pin synchronisers before
  // returning, so that a following byte is not lost to a late START.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start_cond();
    @(posedge clk);
    sda <= 1'b1;
    @(posedge clk);
    sda <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic toggle_scl(input int k);
    repeat (k) begin
      repeat (20) @(posedge clk);
      scl <= ~scl;
    end
  endtask
  task automatic stop_cond();
    @(posedge clk);
    sda <= 1'b0;
    @(posedge clk);
    sda <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/gpio_led_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_led_regs_tb;
  localparam int PHASE_GAP = 32 * 40;
  logic clk, nrst, txn_begin, txn_read, rx_valid, tx_req;
  logic [7:0] rx_data, q, r, a;
  wire scl, sda, txn_abort, bus_ignore, timeout_disable;
  wire [7:0] tx_data_ff, pointer_ff;
  wire [3:0] led_en, phase;
  int mismatches = 0, compares = 0, cyc = 0, n;
  gpio_led_regs #(.TIMEOUT_CYC(24'd50)) uut (.clk(clk), .nrst(nrst), .scl_pin(scl),
    .sda_pin(sda), .txn_begin(txn_begin), .txn_read(txn_read), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_req(tx_req), .tx_data_ff(tx_data_ff), .txn_abort(txn_abort),
    .bus_ignore(bus_ignore), .timeout_disable(timeout_disable),
    .constant_current_ports_led_en(led_en), .led_phase_start_ff(phase),
    .pointer_ff(pointer_ff));
  i2c_host_model host (.clk(clk), .scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] exp_of(input logic [7:0] ad, input logic [7:0] d);
    return (ad == 8'h01) ? {7'b0000101, d[0]} : {4'h0, d[3:0]};
  endfunction
  task automatic go(input logic rd);
    @(posedge clk);
    txn_begin <= 1'b1;
    txn_read <= rd;
    @(posedge clk);
    txn_begin <= 1'b0;
  endtask
  task automatic put(input logic [7:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    #1;
  endtask
  task automatic get(output logic [7:0] d);
    @(posedge clk);
    tx_req <= 1'b1;
    @(posedge clk);
    tx_req <= 1'b0;
    #1;
    d = tx_data_ff;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    go(1'b0);
    put(ad);
    put(d);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    go(1'b0);
    put(ad);
    go(1'b1);
    get(d);
  endtask
  task automatic wait_until(input int idx, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((idx < 4 ? phase[idx[1:0]] : txn_abort) !== 1'b1 && n < lim);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {nrst, txn_begin, txn_read, rx_valid, tx_req} = 5'h00;
    rx_data = 8'h00;
    n = $urandom(33);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h01, q);
    chk(q, 8'h0b);
    rd(8'h31, q);
    chk(q, 8'h00);
    for (int i = 0; i < 8; i++) begin
      a = i[0] ? 8'h31 : 8'h01;
      r = 8'($urandom);
      wr(a, r);
      rd(a, q);
      chk(q, exp_of(a, r));
    end
    go(1'b0);
    put(8'h5a);
    put(8'h11);
    put(8'h22);
    chk(pointer_ff, 8'h31);
    put(8'h05);
    chk(pointer_ff, 8'h32);
    rd(8'h5b, q);
    get(q);
    chk(q, 8'h05);
    go(1'b0);
    put(8'h40);
    host.stop_cond();
    chk(pointer_ff, 8'h40);
    wr(8'h31, 8'h0f);
    wait_until(0, 12000);
    wait_until(1, 12000);
    chk(8'(n == PHASE_GAP), 8'h01);
    wait_until(2, 2000);
    chk(8'(n == PHASE_GAP), 8'h01);
    wr(8'h40, 8'h10);
    repeat (3) @(posedge clk);
    #1;
    chk({4'h0, led_en}, 8'h00);
    chk({7'h00, timeout_disable}, 8'h01);
    wr(8'h01, 8'h00);
    chk({7'h00, timeout_disable}, 8'h00);
    host.start_cond();
    wait_until(4, 200);
    chk(8'(n >= 45 && n < 70), 8'h01);
    go(1'b0);
    put(8'h31);
    chk(pointer_ff, 8'h01);
    host.start_cond();
    host.toggle_scl(6);
    #1;
    chk({7'h00, bus_ignore}, 8'h00);
    host.stop_cond();
    close_out();
  end
endmodule
`default_nettype wire
